// file: pmbt_threshold_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmbt_regs.svh"
module pmbt_threshold_regs
  import pmbt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic smbalert_o,
  output logic smbalert_oe_n,
  input wire logic [7:0] die_temperature_reading,
  input wire logic [15:0] power_input_voltage,
  input wire logic nvm_load,
  input wire logic [5:0] nvm_warn_code,
  input wire logic [3:0] nvm_ov_code,
  input wire logic status_clear,
  output logic temp_warning_flag,
  output logic input_overvoltage_flag,
  output logic comm_fault_flag,
  output logic invalid_data_flag,
  output logic switching_enable
);

  // ****************************************
  // Link domain: pin sampling and reset
  // ****************************************
  logic link_rst_n;
  logic [1:0] pins_s;
  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  pmbt_sync #(.W(1)) u_rst_sync (.clk(link_clk), .d(resetn), .q(link_rst_n));
  pmbt_sync #(.W(2)) u_pin_sync (.clk(link_clk), .d({scl_i, sda_i}), .q(pins_s));

  // Previous pin levels for edge detection, taken after the synchroniser
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= pins_s[1];
      sda_q_r <= pins_s[0];
    end
  end

  // Start and stop are data edges while the clock stays high
  assign scl_rise = pins_s[1] & ~scl_q_r;
  assign scl_fall = ~pins_s[1] & scl_q_r;
  assign bus_start = scl_q_r & pins_s[1] & sda_q_r & ~pins_s[0];
  assign bus_stop = scl_q_r & pins_s[1] & ~sda_q_r & pins_s[0];

  // ****************************************
  // Link domain: byte engine
  // ****************************************
  pmbt_link_state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] cmd_r;
  logic [7:0] lo_r;
  logic [7:0] tx_r;
  logic ack_r;
  logic rd_ok_r;
  logic sda_oe_n_r;
  logic sda_o_r;
  logic [9:0] rd_copy_r;
  logic cmd_is_otw;
  logic wr_valid;
  logic ack_dec;
  logic tx_state;
  logic [7:0] tx_lo;
  logic [7:0] tx_hi;

  // Read-back words, mantissas exactly as written
  assign cmd_is_otw = (cmd_r == `PMBT_CMD_OTW);
  assign tx_lo = cmd_is_otw ? {2'h0, rd_copy_r[9:4]} : {4'h0, rd_copy_r[3:0]};
  assign tx_hi = cmd_is_otw ? {`PMBT_OTW_EXP, 3'h0} : {`PMBT_VOV_EXP, 3'h0};
  assign tx_state = (st_r == ST_RLO) || (st_r == ST_RHI);

  // Read-only bits must carry their fixed values; shift_r holds the high byte here
  always_comb begin
    if (cmd_is_otw) begin
      wr_valid = (shift_r == {`PMBT_OTW_EXP, 3'h0}) && ((lo_r & `PMBT_OTW_LO_RSVD) == 8'h00);
    end else begin
      wr_valid = (shift_r == {`PMBT_VOV_EXP, 3'h0}) && ((lo_r & `PMBT_VOV_LO_RSVD) == 8'h00);
    end
  end

  // Acknowledge decision for the byte just received
  always_comb begin
    ack_dec = 1'b0;
    unique case (st_r)
      ST_ADDR: ack_dec = (shift_r[7:1] == `PMBT_SLAVE_ADDR) && (!shift_r[0] || rd_ok_r);
      ST_CMD: ack_dec = (shift_r == `PMBT_CMD_OTW) || (shift_r == `PMBT_CMD_VOV);
      ST_WLO: ack_dec = 1'b1;
      ST_WHI: ack_dec = wr_valid;
      ST_IDLE, ST_RLO, ST_RHI: ack_dec = 1'b0;
    endcase
  end

  // Phase sequencing on clock rises; a read needs a command from the same frame
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
      lo_r <= 8'h00;
      tx_r <= 8'h00;
      rd_ok_r <= 1'b0;
    end else if (bus_start) begin
      st_r <= ST_ADDR;
      cnt_r <= 4'h0;
    end else if (bus_stop) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      rd_ok_r <= 1'b0;
    end else if (scl_rise && st_r != ST_IDLE) begin
      if (cnt_r != `PMBT_ACK_BIT) begin
        shift_r <= {shift_r[6:0], pins_s[0]};
        cnt_r <= cnt_r + 4'h1;
      end else begin
        cnt_r <= 4'h0;
        unique case (st_r)
          ST_ADDR: begin
            if (!ack_r) begin
              st_r <= ST_IDLE;
            end else if (shift_r[0]) begin
              st_r <= ST_RLO;
              tx_r <= tx_lo;
            end else begin
              st_r <= ST_CMD;
            end
          end
          ST_CMD: begin
            if (ack_r) begin
              cmd_r <= shift_r;
              rd_ok_r <= 1'b1;
              st_r <= ST_WLO;
            end else begin
              st_r <= ST_IDLE;
            end
          end
          ST_WLO: begin
            lo_r <= shift_r;
            st_r <= ST_WHI;
          end
          ST_WHI: st_r <= ST_IDLE;
          ST_RLO: begin
            // Master acknowledges low byte to fetch the high byte
            if (!pins_s[0]) begin
              st_r <= ST_RHI;
              tx_r <= tx_hi;
            end else begin
              st_r <= ST_IDLE;
            end
          end
          ST_RHI: st_r <= ST_IDLE;
          ST_IDLE: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Data line changes on clock falls and is released at start and stop; enable low means pulling low
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      ack_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      sda_o_r <= 1'b0;
    end else if (bus_start || bus_stop) begin
      sda_oe_n_r <= 1'b1;
    end else if (scl_fall) begin
      if (st_r == ST_IDLE) begin
        sda_oe_n_r <= 1'b1;
      end else if (cnt_r == `PMBT_ACK_BIT) begin
        ack_r <= ack_dec;
        sda_oe_n_r <= ~(ack_dec && !tx_state);
      end else begin
        sda_oe_n_r <= ~(tx_state && !tx_r[3'h7 - cnt_r[2:0]]);
      end
    end
  end

  assign sda_o = sda_o_r;
  assign sda_oe_n = sda_oe_n_r;

  // ****************************************
  // Write hand-off toward the system clock
  // ****************************************
  logic wr_tgl_r;
  logic wr_is_ov_r;
  logic [5:0] wr_mant_r;
  logic wr_bad_r;

  // Data is held until the next write, many link cycles away, so a toggle suffices
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      wr_tgl_r <= 1'b0;
      wr_is_ov_r <= 1'b0;
      wr_mant_r <= 6'h00;
      wr_bad_r <= 1'b0;
    end else if (scl_fall && st_r == ST_WHI && cnt_r == `PMBT_ACK_BIT) begin
      wr_tgl_r <= ~wr_tgl_r;
      wr_is_ov_r <= !cmd_is_otw;
      wr_mant_r <= lo_r[5:0];
      wr_bad_r <= !wr_valid;
    end
  end

  // ****************************************
  // Read-back copy: handshake from the system clock
  // ****************************************
  logic pub_tgl_r;
  logic [9:0] pub_data_r;
  logic pub_tgl_s;
  logic pub_seen_r;

  pmbt_sync #(.W(1)) u_pub_sync (.clk(link_clk), .d(pub_tgl_r), .q(pub_tgl_s));

  // Capture only once the request toggle is seen; data is frozen until acknowledged
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      pub_seen_r <= 1'b0;
      rd_copy_r <= {`PMBT_OTW_DEFAULT, `PMBT_VOV_DEFAULT};
    end else if (pub_tgl_s != pub_seen_r) begin
      pub_seen_r <= pub_tgl_s;
      rd_copy_r <= pub_data_r;
    end
  end

  // ****************************************
  // System domain: mantissas and publish
  // ****************************************
  logic [5:0] warn_mant_r;
  logic [3:0] ov_mant_r;
  logic wr_s;
  logic wr_q_r;
  logic wr_evt;
  logic ack_s;
  pmbt_temp_t warn_thr;
  pmbt_mv_t ov_thr;
  logic [5:0] nvm_warn_canon;
  logic [3:0] nvm_ov_canon;

  pmbt_sync #(.W(1)) u_wr_sync (.clk(sys_clk), .d(wr_tgl_r), .q(wr_s));
  pmbt_sync #(.W(1)) u_ack_sync (.clk(sys_clk), .d(pub_seen_r), .q(ack_s));

  // Applied thresholds from live mantissas
  pmbt_quant u_live_quant (
    .warn_code(warn_mant_r),
    .ov_code(ov_mant_r),
    .warn_thr(warn_thr),
    .warn_canon(),
    .ov_thr(ov_thr),
    .ov_canon()
  );

  // Canonical codes for values restored from storage
  pmbt_quant u_nvm_quant (
    .warn_code(nvm_warn_code),
    .ov_code(nvm_ov_code),
    .warn_thr(),
    .warn_canon(nvm_warn_canon),
    .ov_thr(),
    .ov_canon(nvm_ov_canon)
  );

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_q_r <= 1'b0;
    end else begin
      wr_q_r <= wr_s;
    end
  end

  assign wr_evt = wr_s ^ wr_q_r;

  // An accepted host write beats a storage restore landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      warn_mant_r <= `PMBT_OTW_DEFAULT;
      ov_mant_r <= `PMBT_VOV_DEFAULT;
    end else if (wr_evt && !wr_bad_r) begin
      if (wr_is_ov_r) begin
        ov_mant_r <= wr_mant_r[3:0];
      end else begin
        warn_mant_r <= wr_mant_r;
      end
    end else if (nvm_load) begin
      warn_mant_r <= nvm_warn_canon;
      ov_mant_r <= nvm_ov_canon;
    end
  end

  // Publish a new snapshot only when the previous one has been taken
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pub_tgl_r <= 1'b0;
      pub_data_r <= {`PMBT_OTW_DEFAULT, `PMBT_VOV_DEFAULT};
    end else if (pub_tgl_r == ack_s && pub_data_r != {warn_mant_r, ov_mant_r}) begin
      pub_tgl_r <= ~pub_tgl_r;
      pub_data_r <= {warn_mant_r, ov_mant_r};
    end
  end

  // ****************************************
  // System domain: comparators, flags, alert
  // ****************************************
  logic warn_hit;
  logic ov_hit;
  logic temp_flag_nxt;
  logic vin_flag_nxt;
  logic cml_flag_nxt;
  logic ivd_flag_nxt;
  logic temp_warning_flag_r;
  logic input_overvoltage_flag_r;
  logic comm_fault_flag_r;
  logic invalid_data_flag_r;
  logic switching_enable_r;
  logic smbalert_oe_n_r;
  logic smbalert_o_r;

  // Telemetry is unsigned degrees; negative readings must arrive clamped to zero
  assign warn_hit = (die_temperature_reading >= warn_thr);
  assign ov_hit = (power_input_voltage >= ov_thr);

  // Sticky flags: a new event wins over a clear in the same cycle
  always_comb begin
    temp_flag_nxt = (temp_warning_flag_r && !status_clear) || warn_hit;
    vin_flag_nxt = (input_overvoltage_flag_r && !status_clear) || ov_hit;
    cml_flag_nxt = (comm_fault_flag_r && !status_clear) || (wr_evt && wr_bad_r);
    ivd_flag_nxt = (invalid_data_flag_r && !status_clear) || (wr_evt && wr_bad_r);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      temp_warning_flag_r <= 1'b0;
      input_overvoltage_flag_r <= 1'b0;
      comm_fault_flag_r <= 1'b0;
      invalid_data_flag_r <= 1'b0;
      smbalert_oe_n_r <= 1'b1;
      smbalert_o_r <= 1'b0;
    end else begin
      temp_warning_flag_r <= temp_flag_nxt;
      input_overvoltage_flag_r <= vin_flag_nxt;
      comm_fault_flag_r <= cml_flag_nxt;
      invalid_data_flag_r <= ivd_flag_nxt;
      smbalert_oe_n_r <= ~(temp_flag_nxt | vin_flag_nxt | cml_flag_nxt | ivd_flag_nxt);
    end
  end

  // Latch-off only; no retry path exists, only reset restarts switching
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      switching_enable_r <= 1'b1;
    end else if (ov_hit) begin
      switching_enable_r <= 1'b0;
    end
  end

  assign temp_warning_flag = temp_warning_flag_r;
  assign input_overvoltage_flag = input_overvoltage_flag_r;
  assign comm_fault_flag = comm_fault_flag_r;
  assign invalid_data_flag = invalid_data_flag_r;
  assign switching_enable = switching_enable_r;
  assign smbalert_oe_n = smbalert_oe_n_r;
  assign smbalert_o = smbalert_o_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_warn_alert;
    @(posedge sys_clk) disable iff (!resetn)
      warn_hit |=> temp_warning_flag_r && !smbalert_oe_n_r;
  endproperty
  a_warn_alert: assert property (p_warn_alert) else $error("warning not flagged");

  property p_ov_alert;
    @(posedge sys_clk) disable iff (!resetn)
      ov_hit |=> input_overvoltage_flag_r && !smbalert_oe_n_r;
  endproperty
  a_ov_alert: assert property (p_ov_alert) else $error("overvoltage not flagged");

  sequence s_latched;
    !switching_enable_r [*4];
  endsequence
  property p_latch_off;
    @(posedge sys_clk) disable iff (!resetn)
      ov_hit |=> s_latched;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("switching not latched off");

  property p_bad_write;
    @(posedge sys_clk) disable iff (!resetn)
      (wr_evt && wr_bad_r) |=> comm_fault_flag_r && invalid_data_flag_r
        && $stable(warn_mant_r) && $stable(ov_mant_r);
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("invalid write not handled");

  property p_good_write;
    @(posedge sys_clk) disable iff (!resetn)
      (wr_evt && !wr_bad_r && !wr_is_ov_r) |=> warn_mant_r == $past(wr_mant_r);
  endproperty
  a_good_write: assert property (p_good_write) else $error("mantissa not kept as written");

  property p_warn_quant;
    @(posedge sys_clk) disable iff (!resetn)
      (warn_mant_r >= `PMBT_OTW_C130) |-> warn_thr == `PMBT_T130;
  endproperty
  a_warn_quant: assert property (p_warn_quant) else $error("warning range wrong");

  property p_ov_quant;
    @(posedge sys_clk) disable iff (!resetn)
      (ov_mant_r < `PMBT_VOV_C185) |-> ov_thr == `PMBT_V165;
  endproperty
  a_ov_quant: assert property (p_ov_quant) else $error("overvoltage range wrong");

  property p_nvm_canon;
    @(posedge sys_clk) disable iff (!resetn)
      (nvm_load && !wr_evt) |=> warn_mant_r == $past(nvm_warn_canon);
  endproperty
  a_nvm_canon: assert property (p_nvm_canon) else $error("restore not canonical");

  property p_cmd_ack;
    @(posedge link_clk) disable iff (!link_rst_n)
      (scl_fall && st_r == ST_CMD && cnt_r == `PMBT_ACK_BIT && shift_r == `PMBT_CMD_OTW)
        |=> !sda_oe_n_r;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("command not acknowledged");

  property p_wr_nack;
    @(posedge link_clk) disable iff (!link_rst_n)
      (scl_fall && st_r == ST_WHI && cnt_r == `PMBT_ACK_BIT && !wr_valid) |=> sda_oe_n_r;
  endproperty
  a_wr_nack: assert property (p_wr_nack) else $error("bad write acknowledged");
endmodule
`default_nettype wire

// file: pmbt_regs.svh
// Operation
// - Temperature warning threshold answers command 51h by word write and word read.
// - Die temperature telemetry is compared against the applied warning threshold continuously.
// - A warning sets the temperature warning flag and asserts the alert line.
// - Warning word: exponent 00010b in 15:11, zero 10:6, writable mantissa 5:0.
// - Warning mantissa loads from storage; the factory default means 125 degrees.
// - Written mantissas read back unchanged; hardware applies the nearest supported setting.
// - A mantissa restored from storage is the canonical code of its setting.
// - Writes touching read-only bits are refused, discarded, and set comm-fault and invalid-data.
// - Warning code maps to 95,100,105,110,115,120,125,130 degrees by fixed ranges.
// - Input overvoltage threshold answers command 55h by word write and word read.
// - An input overvoltage fault always latches switching off, with no retry.
// - An input overvoltage fault sets the input flag and asserts the alert line.
// - Overvoltage word: exponent 00001b in 15:11, zero 10:4, writable mantissa 3:0.
// - Overvoltage mantissa loads from storage; factory default 1001b selects 18.5 volts.
// - Overvoltage codes below 9 select 16.5 volts, codes 9 to 15 select 18.5.
`ifndef PMBT_REGS_SVH
`define PMBT_REGS_SVH

// ****************************************
// Command codes and bus constants
// ****************************************
`define PMBT_CMD_OTW 8'h51
`define PMBT_CMD_VOV 8'h55
`define PMBT_SLAVE_ADDR 7'h24
`define PMBT_ACK_BIT 4'h8

// ****************************************
// Word layouts
// ****************************************
`define PMBT_OTW_EXP 5'h02
`define PMBT_VOV_EXP 5'h01
`define PMBT_OTW_LO_RSVD 8'hC0
`define PMBT_VOV_LO_RSVD 8'hF0

// ****************************************
// Reset codes and range bounds (bounds double as canonical codes)
// ****************************************
`define PMBT_OTW_DEFAULT 6'h1F
`define PMBT_VOV_DEFAULT 4'h9
`define PMBT_OTW_C95 6'h00
`define PMBT_OTW_C100 6'h19
`define PMBT_OTW_C105 6'h1A
`define PMBT_OTW_C110 6'h1B
`define PMBT_OTW_C115 6'h1D
`define PMBT_OTW_C120 6'h1E
`define PMBT_OTW_C125 6'h1F
`define PMBT_OTW_C130 6'h20
`define PMBT_VOV_C165 4'h0
`define PMBT_VOV_C185 4'h9

// ****************************************
// Applied thresholds, degrees C and millivolts
// ****************************************
`define PMBT_T95 8'h5F
`define PMBT_T100 8'h64
`define PMBT_T105 8'h69
`define PMBT_T110 8'h6E
`define PMBT_T115 8'h73
`define PMBT_T120 8'h78
`define PMBT_T125 8'h7D
`define PMBT_T130 8'h82
`define PMBT_V165 16'h4074
`define PMBT_V185 16'h4844

`endif

// file: pmbt_pkg.sv
`default_nettype none
package pmbt_pkg;
  // Link byte engine phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WLO,
    ST_WHI,
    ST_RLO,
    ST_RHI
  } pmbt_link_state_t;
  typedef logic [7:0] pmbt_temp_t;
  typedef logic [15:0] pmbt_mv_t;
endpackage
`default_nettype wire

// file: pmbt_sync.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Two-flop synchroniser
// ****************************************
module pmbt_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  // No reset: also used to carry the reset itself into the link domain
  always_ff @(posedge clk) begin
    meta_r <= d;
    hold_r <= meta_r;
  end

  assign q = hold_r;
endmodule
`default_nettype wire

// file: pmbt_quant.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmbt_regs.svh"
// ****************************************
// Mantissa to applied threshold and canonical code
// ****************************************
module pmbt_quant
  import pmbt_pkg::*;
(
  input wire logic [5:0] warn_code,
  input wire logic [3:0] ov_code,
  output pmbt_temp_t warn_thr,
  output logic [5:0] warn_canon,
  output pmbt_mv_t ov_thr,
  output logic [3:0] ov_canon
);
  // Warning ranges, checked from the top so each code hits one branch
  always_comb begin
    if (warn_code >= `PMBT_OTW_C130) begin
      warn_thr = `PMBT_T130;
      warn_canon = `PMBT_OTW_C130;
    end else if (warn_code >= `PMBT_OTW_C125) begin
      warn_thr = `PMBT_T125;
      warn_canon = `PMBT_OTW_C125;
    end else if (warn_code >= `PMBT_OTW_C120) begin
      warn_thr = `PMBT_T120;
      warn_canon = `PMBT_OTW_C120;
    end else if (warn_code >= `PMBT_OTW_C115) begin
      warn_thr = `PMBT_T115;
      warn_canon = `PMBT_OTW_C115;
    end else if (warn_code >= `PMBT_OTW_C110) begin
      warn_thr = `PMBT_T110;
      warn_canon = `PMBT_OTW_C110;
    end else if (warn_code >= `PMBT_OTW_C105) begin
      warn_thr = `PMBT_T105;
      warn_canon = `PMBT_OTW_C105;
    end else if (warn_code >= `PMBT_OTW_C100) begin
      warn_thr = `PMBT_T100;
      warn_canon = `PMBT_OTW_C100;
    end else begin
      warn_thr = `PMBT_T95;
      warn_canon = `PMBT_OTW_C95;
    end
  end

  // Only two input overvoltage settings exist
  always_comb begin
    if (ov_code >= `PMBT_VOV_C185) begin
      ov_thr = `PMBT_V185;
      ov_canon = `PMBT_VOV_C185;
    end else begin
      ov_thr = `PMBT_V165;
      ov_canon = `PMBT_VOV_C165;
    end
  end
endmodule
`default_nettype wire

// file: pmbt_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmbt_regs.svh"
// ****
// Behavioural bus host
// ****
module pmbt_host (
  input wire logic sda,
  output logic scl,
  output logic sda_drv_n
);
  localparam int Q = 300;
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
  end
  // Data moves only mid-low, so the device release never races it
  task automatic bit_slot(input logic b, output logic s);
    #Q sda_drv_n = b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask
  // Start and repeated start share one shape
  task automatic start();
    #Q sda_drv_n = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv_n = 1'b0;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_drv_n = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv_n = 1'b1;
    #(4 * Q);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
    bit_slot(last, s);
  endtask
  // Word write: ok only when every byte was acknowledged
  task automatic wr_word(input logic [7:0] cmd, input logic [15:0] w, output logic ok);
    logic a0, a1, a2, a3;
    start();
    send_byte({`PMBT_SLAVE_ADDR, 1'b0}, a0);
    send_byte(cmd, a1);
    send_byte(w[7:0], a2);
    send_byte(w[15:8], a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask
  // Word read: low byte first, host refuses the last byte
  task automatic rd_word(input logic [7:0] cmd, output logic [15:0] w);
    logic a;
    start();
    send_byte({`PMBT_SLAVE_ADDR, 1'b0}, a);
    send_byte(cmd, a);
    start();
    send_byte({`PMBT_SLAVE_ADDR, 1'b1}, a);
    recv_byte(1'b0, w[7:0]);
    recv_byte(1'b1, w[15:8]);
    stop();
  endtask
endmodule
`default_nettype wire

// file: pmbt_threshold_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module pmbt_threshold_regs_bench;
  import pmbt_pkg::*;
  logic sys_clk = 1'b0, link_clk = 1'b0, resetn = 1'b0;
  logic scl, host_n, sda, sda_o, sda_oe_n, smbalert_oe_n, ok;
  logic nvm_load = 1'b0, status_clear = 1'b0;
  logic [5:0] nvm_warn_code = 6'h00;
  logic [3:0] nvm_ov_code = 4'h0;
  logic [7:0] temp = 8'h00;
  logic [15:0] vin = 16'h0000, w;
  logic t_flag, v_flag, cml, ivd, sw_en, alert_o;
  int bad_count = 0, cmp_count = 0, m;
  int codes[8] = '{24, 25, 26, 28, 29, 30, 31, 63};
  // ****
  // Clocks, wire and instances
  // ****
  always #5 sys_clk = ~sys_clk;
  // Link clock offset so its edges never line up with the system clock
  initial begin
    #3.3;
    forever #32 link_clk = ~link_clk;
  end
  // Open-drain wire with pull-up
  assign sda = (sda_oe_n | sda_o) & host_n;
  pmbt_host pmbt_host_inst (.sda(sda), .scl(scl), .sda_drv_n(host_n));
  pmbt_threshold_regs pmbt_threshold_regs_inst (
    .sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .smbalert_o(alert_o),
    .smbalert_oe_n(smbalert_oe_n), .die_temperature_reading(temp),
    .power_input_voltage(vin), .nvm_load(nvm_load), .nvm_warn_code(nvm_warn_code),
    .nvm_ov_code(nvm_ov_code), .status_clear(status_clear),
    .temp_warning_flag(t_flag), .input_overvoltage_flag(v_flag),
    .comm_fault_flag(cml), .invalid_data_flag(ivd), .switching_enable(sw_en));
  // ****
  // Model and checks
  // ****
  function automatic int warn_deg(input int c);
    if (c < 25) return 95;
    if (c < 27) return 100 + 5 * (c - 25);
    if (c < 29) return 110;
    if (c < 32) return 115 + 5 * (c - 29);
    return 130;
  endfunction
  task automatic check_word(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic pulse_clear();
    @(negedge sys_clk) status_clear = 1'b1;
    @(negedge sys_clk) status_clear = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  // One below the applied threshold must stay quiet, the threshold itself must hit
  task automatic probe(input bit ov, input int thr);
    for (int k = 0; k < 2; k++) begin
      @(negedge sys_clk);
      if (ov) vin = 16'(thr - 1 + k);
      else temp = 8'(thr - 1 + k);
      repeat (3) @(negedge sys_clk);
      check_bit("hit", 1'(k), ov ? v_flag : t_flag);
      check_bit("alert_n", ~1'(k), smbalert_oe_n);
    end
    temp = 8'h00;
    vin = 16'h0000;
    pulse_clear();
  endtask
  // Hang guard: roughly a tenth beyond the expected run length
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(32'h48a6));
    // Held long enough for the link-side reset synchroniser as well
    repeat (26) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (40) @(negedge sys_clk);
    pmbt_host_inst.rd_word(8'h51, w);
    check_word("warn_word", 16'h101F, w);
    pmbt_host_inst.rd_word(8'h55, w);
    check_word("ov_word", 16'h0809, w);
    check_bit("switch_en", 1'b1, sw_en);
    foreach (codes[i]) begin
      pmbt_host_inst.wr_word(8'h51, {8'h10, 2'b00, 6'(codes[i])}, ok);
      check_bit("warn_ack", 1'b1, ok);
      probe(1'b0, warn_deg(codes[i]));
    end
    m = $urandom_range(63, 0);
    pmbt_host_inst.wr_word(8'h51, {8'h10, 2'b00, 6'(m)}, ok);
    pmbt_host_inst.rd_word(8'h51, w);
    check_word("raw_back", {8'h10, 2'b00, 6'(m)}, w);
    probe(1'b0, warn_deg(m));
    pmbt_host_inst.wr_word(8'h51, 16'h1120, ok);
    check_bit("bad_ack", 1'b0, ok);
    repeat (10) @(negedge sys_clk);
    check_bit("cml", 1'b1, cml);
    check_bit("ivd", 1'b1, ivd);
    check_bit("alert_n", 1'b0, smbalert_oe_n);
    check_bit("alert_drv", 1'b0, alert_o);
    pmbt_host_inst.rd_word(8'h51, w);
    check_word("kept", {8'h10, 2'b00, 6'(m)}, w);
    pulse_clear();
    // A command outside the two thresholds is refused without raising flags
    pmbt_host_inst.wr_word(8'h52, 16'h1019, ok);
    check_bit("cmd_nack", 1'b0, ok);
    check_bit("cml_quiet", 1'b0, cml);
    nvm_warn_code = 6'h1C;
    nvm_ov_code = 4'h5;
    @(negedge sys_clk) nvm_load = 1'b1;
    @(negedge sys_clk) nvm_load = 1'b0;
    pmbt_host_inst.rd_word(8'h51, w);
    check_word("nvm_warn", 16'h101B, w);
    pmbt_host_inst.rd_word(8'h55, w);
    check_word("nvm_ov", 16'h0800, w);
    probe(1'b1, 16500);
    check_bit("latched", 1'b0, sw_en);
    pmbt_host_inst.wr_word(8'h55, 16'h080C, ok);
    check_bit("ov_ack", 1'b1, ok);
    probe(1'b1, 18500);
    check_bit("still_off", 1'b0, sw_en);
    complete_run();
  end
endmodule
`default_nettype wire
